// ---- core/pcv_vector.v ----
// capability configuration vector, bits 113..191, with wishbone readback
// assumes static vector inputs tied by the integrator; classic wishbone master
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "pcv_consts.vh"

// Behaviour
// R1: low priority VC count reported in VC reg1
// R2: VC arbitration field fixed to 0001
// R3: L0s acceptable latency code to device caps
// R4: L1 acceptable latency code to device caps
// R5: max link width, only 1 or 4
// R6: ASPM support 01 or 11 only
// R7: first L1 exit latency field reported
// R8: second L1 exit latency field reported
// R9: outstanding tags never exceed configured count
// R10: reserved slices tied to zero by integrator
module pcv_vector (
    input wire clk_i, // clock, 100 MHz
    input wire rst_i, // sync reset, high
    input wire ce_i, // clock enable
    input wire [78:0] cfg_vec_i, // vector bits 191..113
    input wire tag_alloc_i, // want a tag for a request
    input wire tag_free_i, // completion returned a tag
    output reg tag_grant_o, // tag granted
    output reg tag_full_o, // no free tag
    output reg [2:0] lp_vc_o, // low priority vc count
    output reg [3:0] vc_arb_o, // vc arbitration capability
    output reg [2:0] l0s_acc_o, // l0s acceptable latency
    output reg [2:0] l1_acc_o, // l1 acceptable latency
    output reg [5:0] max_width_o, // maximum link width
    output reg [1:0] aspm_o, // aspm support
    output reg [2:0] l1_exit_a_o, // l1 exit latency, bits 156:154
    output reg [2:0] l1_exit_b_o, // l1 exit latency, bits 159:157
    output reg [2:0] tags_o, // tags supported code
    output reg cfg_err_o, // illegal or nonzero reserved field
    input wire [7:0] wb_adr_i, // wishbone address
    input wire [31:0] wb_dat_i, // wishbone write data
    input wire [3:0] wb_sel_i, // wishbone byte select
    input wire wb_we_i, // wishbone write enable
    input wire wb_cyc_i, // wishbone cycle
    input wire wb_stb_i, // wishbone strobe
    output reg [31:0] wb_dat_o, // wishbone read data
    output reg wb_ack_o, // wishbone ack
    output reg wb_err_o // wishbone error, unmapped address
);
    // slice of the full vector at absolute position lsb
    function [5:0] fld;
        input [78:0] v;
        input integer lsb;
        input integer w;
        integer k;
        begin
            fld = 6'h00;
            for (k = 0; k < 6; k = k + 1)
                if (k < w)
                    fld[k] = v[lsb - `PCV_VEC_LSB + k];
        end
    endfunction

    // high when every absolute bit from lsb to msb is zero
    function slice_zero;
        input [78:0] v;
        input integer lsb;
        input integer msb;
        integer k;
        begin
            slice_zero = 1'b1;
            for (k = 0; k < `PCV_VEC_W; k = k + 1)
                if (k >= lsb - `PCV_VEC_LSB && k <= msb - `PCV_VEC_LSB && v[k])
                    slice_zero = 1'b0;
        end
    endfunction

    wire [78:0] v = cfg_vec_i;

    // raw field slices, cut down from the six-bit helper
    wire [5:0] lpvc_raw = fld(v, `PCV_LPVC_LSB, 3);
    wire [5:0] l0s_raw = fld(v, `PCV_L0S_LSB, 3);
    wire [5:0] l1acc_raw = fld(v, `PCV_L1ACC_LSB, 3);
    wire [5:0] width_raw = fld(v, `PCV_WIDTH_LSB, 6);
    wire [5:0] exa_raw = fld(v, `PCV_EXA_LSB, 3);
    wire [5:0] exb_raw = fld(v, `PCV_EXB_LSB, 3);
    wire [5:0] tags_raw = fld(v, `PCV_TAGS_LSB, 3);
    wire [5:0] aspm_wide = fld(v, `PCV_ASPM_LSB, 2);
    wire [5:0] arb_wide = fld(v, `PCV_VCARB_LSB, 4);
    wire [1:0] aspm_raw = aspm_wide[1:0];
    wire [3:0] arb_raw = arb_wide[3:0];

    // fields that only take some codes
    wire width_ok = (width_raw == `PCV_WIDTH_X1) || (width_raw == `PCV_WIDTH_X4); // R5
    wire aspm_ok = (aspm_raw == `PCV_ASPM_L0S) || (aspm_raw == `PCV_ASPM_BOTH); // R6
    wire arb_ok = (arb_raw == `PCV_VCARB_FIXED); // R2

    // reserved slices must be tied low
    wire rsv_a_ok = slice_zero(v, `PCV_RSV_A_LSB, `PCV_RSV_A_MSB);
    wire rsv_b_ok = slice_zero(v, `PCV_RSV_B_LSB, `PCV_RSV_B_MSB);
    wire rsv_c_ok = slice_zero(v, `PCV_RSV_C_LSB, `PCV_RSV_C_MSB);
    wire rsv_d_ok = slice_zero(v, `PCV_RSV_D_LSB, `PCV_RSV_D_MSB);
    wire resv_ok = rsv_a_ok && rsv_b_ok && rsv_c_ok && rsv_d_ok; // R10
    wire all_ok = width_ok && aspm_ok && arb_ok && resv_ok;

    reg [2:0] tag_ctl_reg; // software cap below configured tags
    wire [2:0] tag_cfg = tags_raw[2:0];
    wire tag_cap = (tag_ctl_reg != 3'h0) && (tag_ctl_reg < tag_cfg);
    wire [2:0] tag_eff = tag_cap ? tag_ctl_reg : tag_cfg;
    wire grant;
    wire full;
    wire [5:0] in_use;

    pcv_tag_pool u_pool (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tag_code_i(tag_eff),
        .alloc_i(tag_alloc_i),
        .free_i(tag_free_i),
        .grant_o(grant),
        .count_o(in_use),
        .at_limit_o(full)
    );

    // port vc capability fields
    always @(posedge clk_i) begin
        if (rst_i) begin
            lp_vc_o <= 3'h0;
            vc_arb_o <= `PCV_VCARB_FIXED;
        end else if (ce_i) begin
            lp_vc_o <= lpvc_raw[2:0]; // R1
            vc_arb_o <= `PCV_VCARB_FIXED; // R2
        end
    end

    // device capability latency codes, passed through unchanged
    always @(posedge clk_i) begin
        if (rst_i) begin
            l0s_acc_o <= 3'h0;
            l1_acc_o <= 3'h0;
        end else if (ce_i) begin
            l0s_acc_o <= l0s_raw[2:0]; // R3
            l1_acc_o <= l1acc_raw[2:0]; // R4
        end
    end

    // link width and aspm keep their last legal code
    always @(posedge clk_i) begin
        if (rst_i) begin
            max_width_o <= `PCV_WIDTH_X1;
            aspm_o <= `PCV_ASPM_L0S;
        end else if (ce_i) begin
            if (width_ok)
                max_width_o <= width_raw; // R5
            if (aspm_ok)
                aspm_o <= aspm_raw; // R6
        end
    end

    // link capability exit latencies
    always @(posedge clk_i) begin
        if (rst_i) begin
            l1_exit_a_o <= 3'h0;
            l1_exit_b_o <= 3'h0;
        end else if (ce_i) begin
            l1_exit_a_o <= exa_raw[2:0]; // R7
            l1_exit_b_o <= exb_raw[2:0]; // R8
        end
    end

    // tag code, configuration error and tag pool outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            tags_o <= 3'h0;
            cfg_err_o <= 1'b0;
            tag_grant_o <= 1'b0;
            tag_full_o <= 1'b0;
        end else if (ce_i) begin
            tags_o <= tag_cfg; // R9
            cfg_err_o <= !all_ok;
            tag_grant_o <= grant; // R9
            tag_full_o <= full; // R9
        end
    end

    // wishbone slave, answers one cycle after strobe
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    reg hit;
    reg [31:0] rd;

    // read data only on mapped reads; write to tag cap on byte lane 0
    wire rd_take = req && hit && !wb_we_i;
    wire wr_tagctl = req && hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `PCV_OFF_TAGCTL);

    always @* begin
        hit = 1'b1;
        rd = 32'h00000000;
        case (wb_adr_i)
            `PCV_OFF_VCCAP: rd = {25'h0, vc_arb_o, lp_vc_o};
            `PCV_OFF_DEVCAP: rd = {26'h0, l1_acc_o, l0s_acc_o};
            `PCV_OFF_LNKCAP: rd = {18'h0, l1_exit_b_o, l1_exit_a_o, aspm_o, max_width_o};
            `PCV_OFF_TAGCTL: rd = {29'h0, tag_ctl_reg};
            `PCV_OFF_STATUS: rd = {23'h0, cfg_err_o, tag_full_o, in_use, tags_o[0]};
            default: hit = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= rd_take ? rd : 32'h00000000;
        end
    end

    // tag cap register
    always @(posedge clk_i) begin
        if (rst_i) begin
            tag_ctl_reg <= 3'h0;
        end else if (ce_i) begin
            if (wr_tagctl)
                tag_ctl_reg <= wb_dat_i[2:0];
        end
    end
endmodule // pcv_vector

// ---- core/pcv_consts.vh ----
// constants for the capability configuration vector slice (bits 113..191)
// assumes inclusion by core/pcv_vector.v and core/pcv_tag_pool.v
`ifndef PCV_CONSTS_VH
`define PCV_CONSTS_VH

`define PCV_VEC_LSB 113
`define PCV_VEC_MSB 191
`define PCV_VEC_W 79

// field positions within the full vector
`define PCV_LPVC_LSB 113
`define PCV_VCARB_LSB 116
`define PCV_L0S_LSB 134
`define PCV_L1ACC_LSB 137
`define PCV_WIDTH_LSB 146
`define PCV_ASPM_LSB 152
`define PCV_EXA_LSB 154
`define PCV_EXB_LSB 157
`define PCV_TAGS_LSB 167

// reserved slices, absolute bit ranges
`define PCV_RSV_A_LSB 120
`define PCV_RSV_A_MSB 133
`define PCV_RSV_B_LSB 140
`define PCV_RSV_B_MSB 145
`define PCV_RSV_C_LSB 160
`define PCV_RSV_C_MSB 166
`define PCV_RSV_D_LSB 170
`define PCV_RSV_D_MSB 191

// fixed values
`define PCV_VCARB_FIXED 4'h1
`define PCV_WIDTH_X1 6'h01
`define PCV_WIDTH_X4 6'h04
`define PCV_ASPM_L0S 2'h1
`define PCV_ASPM_BOTH 2'h3

// register offsets (byte addresses)
`define PCV_OFF_VCCAP 8'h00
`define PCV_OFF_DEVCAP 8'h04
`define PCV_OFF_LNKCAP 8'h08
`define PCV_OFF_TAGCTL 8'h0C
`define PCV_OFF_STATUS 8'h10

// reset values of software registers
`define PCV_TAGCTL_RST 32'h00000000
`define PCV_CAP_RST 32'h00000000

// L0s acceptable latency base, ns; code n spans up to base << n
`define PCV_L0S_BASE_NS 64
`define PCV_L1_BASE_NS 1000
`define PCV_CLK_NS 10

`endif

// ---- core/pcv_tag_pool.v ----
// outstanding tag tracker for transmitted non-posted requests
// assumes a single clock, synchronous reset and a static tag limit
`timescale 1ns/1ns
`include "pcv_consts.vh"

module pcv_tag_pool (
    input wire clk_i, // clock
    input wire rst_i, // sync reset, high
    input wire ce_i, // clock enable
    input wire [2:0] tag_code_i, // configured tag count code
    input wire alloc_i, // request to take a tag
    input wire free_i, // a completion returns a tag
    output reg grant_o, // tag taken this cycle
    output reg [5:0] count_o, // tags in use
    output reg at_limit_o // no tag free
);
    reg [5:0] limit;

    // code n allows n+1 tags, at least one
    always @* begin
        limit = {3'h0, tag_code_i} + 6'h01;
    end

    wire can_take = (count_o < limit) && alloc_i;
    wire do_free = free_i && (count_o != 6'h00);

    always @(posedge clk_i) begin
        if (rst_i) begin
            grant_o <= 1'b0;
            count_o <= 6'h00;
            at_limit_o <= 1'b0;
        end else if (ce_i) begin
            grant_o <= can_take; // R9
            if (can_take && !do_free)
                count_o <= count_o + 6'h01;
            else if (!can_take && do_free)
                count_o <= count_o - 6'h01;
            at_limit_o <= (count_o + {5'h00, can_take} - {5'h00, do_free}) >= limit; // R9
        end
    end
endmodule // pcv_tag_pool

// ---- bench/pcv_tie_model.sv ----
// integrator tie-off model for vector bits 191..113
// assumes the bench picks field codes; static between tests
`timescale 1ns/1ns
module pcv_tie_model (
    input wire [2:0] code_i, // code for the 3-bit fields
    input wire wide_i, // four lanes
    input wire both_i, // l1 and l0s
    input wire rsv_bad_i, // dirty reserved bit on purpose
    output logic [78:0] cfg_vec_o // vector bits 191..113
);
    always_comb begin
        cfg_vec_o = 79'h0;
        cfg_vec_o[57] = rsv_bad_i;
        cfg_vec_o[2:0] = code_i;
        cfg_vec_o[6:3] = 4'h1;
        cfg_vec_o[23:21] = code_i;
        cfg_vec_o[26:24] = code_i;
        cfg_vec_o[38:33] = wide_i ? 6'h04 : 6'h01;
        cfg_vec_o[40:39] = both_i ? 2'h3 : 2'h1;
        cfg_vec_o[43:41] = code_i;
        cfg_vec_o[46:44] = ~code_i;
        cfg_vec_o[56:54] = code_i;
    end
endmodule // pcv_tie_model

// ---- bench/pcv_vector_asserts.sv ----
// checker on the ports of pcv_vector
// assumes one clock, synchronous reset
`timescale 1ns/1ns
module pcv_vector_asserts (
    input wire clk_i, // clock
    input wire rst_i, // reset
    input wire ce_i, // clock enable
    input wire [78:0] cfg_vec_i, // vector
    input wire [2:0] lp_vc_o, // low priority vc
    input wire [3:0] vc_arb_o, // arbitration
    input wire [2:0] l0s_acc_o, // l0s latency
    input wire [2:0] l1_acc_o, // l1 latency
    input wire [5:0] max_width_o, // width
    input wire [1:0] aspm_o, // aspm
    input wire [2:0] l1_exit_a_o, // exit a
    input wire [2:0] l1_exit_b_o, // exit b
    input wire [2:0] tags_o, // tags code
    input wire cfg_err_o, // config error
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_ack_o, // ack
    input wire wb_err_o // error
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence wb_ans_s;
        (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
    endsequence
    vc_arb_fixed_a: assert property (vc_arb_o == 4'h1) else $error("arb field wrong");
    lpvc_copy_a: assert property (ce_i |=> lp_vc_o == $past(cfg_vec_i[2:0]))
        else $error("lp vc wrong");
    acc_lat_copy_a: assert property (ce_i |=> {l1_acc_o, l0s_acc_o} == $past(cfg_vec_i[26:21]))
        else $error("acceptable latency wrong");
    exit_lat_copy_a: assert property (ce_i |=> {l1_exit_b_o, l1_exit_a_o} == $past(cfg_vec_i[46:41]))
        else $error("exit latency wrong");
    width_legal_a: assert property (max_width_o == 6'h01 || max_width_o == 6'h04)
        else $error("width illegal");
    aspm_legal_a: assert property (aspm_o == 2'h1 || aspm_o == 2'h3) else $error("aspm illegal");
    tags_copy_a: assert property (ce_i |=> tags_o == $past(cfg_vec_i[56:54]))
        else $error("tags code wrong");
    reserved_err_a: assert property (ce_i && (|cfg_vec_i[20:7] || |cfg_vec_i[32:27] ||
        |cfg_vec_i[53:47] || |cfg_vec_i[78:57]) |=> cfg_err_o) else $error("reserved missed");
    wb_answer_a: assert property (wb_req_s |=> wb_ans_s) else $error("bus answer wrong");
    freeze_hold_a: assert property (!ce_i |=> $stable({lp_vc_o, l0s_acc_o, l1_acc_o, tags_o}))
        else $error("fields moved while frozen");
endmodule // pcv_vector_asserts
bind pcv_vector pcv_vector_asserts u_chk (.*);

// ---- bench/test_pcie_capability_config_vector.sv ----
// self-checking bench for pcv_vector
// assumes the tie model drives the vector
`timescale 1ns/1ns
module test_pcie_capability_config_vector;
    logic clk_i = 1'b0, rst_i = 1'b1, tag_alloc_i = 1'b0, wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wide = 1'b0, both = 1'b0, rsv_bad = 1'b0, got_err;
    logic ce_i = 1'b1, tag_free_i = 1'b0;
    logic [2:0] code = 3'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, rd, grants;
    wire [78:0] cfg_vec;
    wire [31:0] wb_dat_o;
    wire [2:0] lp_vc, l0s, l1, exa, exb, tags;
    wire [3:0] arb;
    wire [5:0] width;
    wire [1:0] aspm;
    wire tag_grant, tag_full, cfg_err, wb_ack_o, wb_err_o;
    int n_mismatch = 0, n_checks = 0;
    pcv_tie_model u_tie (.code_i(code), .wide_i(wide), .both_i(both), .rsv_bad_i(rsv_bad),
        .cfg_vec_o(cfg_vec));
    pcv_vector dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_vec_i(cfg_vec),
        .tag_alloc_i(tag_alloc_i), .tag_free_i(tag_free_i), .tag_grant_o(tag_grant),
        .tag_full_o(tag_full), .lp_vc_o(lp_vc), .vc_arb_o(arb), .l0s_acc_o(l0s), .l1_acc_o(l1),
        .max_width_o(width), .aspm_o(aspm), .l1_exit_a_o(exa), .l1_exit_b_o(exb), .tags_o(tags),
        .cfg_err_o(cfg_err), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        got_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("bus answer", 1, n < 20);
        @(posedge clk_i);
    endtask
    task automatic burst;
        grants = 32'h0;
        tag_alloc_i <= 1'b1;
        repeat (8) begin
            @(posedge clk_i);
            grants = grants + tag_grant;
        end
        tag_alloc_i <= 1'b0;
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_i);
        n_mismatch++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            code <= i[2:0];
            wide <= i[0];
            both <= i[1];
            repeat (2) @(posedge clk_i);
            wb(8'h00, 1'b0, 32'h0);
            chk("vc reg", {25'h0, 4'h1, i[2:0]}, rd);
            wb(8'h04, 1'b0, 32'h0);
            chk("dev lat", {26'h0, i[2:0], i[2:0]}, rd);
            wb(8'h08, 1'b0, 32'h0);
            chk("link cap", {18'h0, ~i[2:0], i[2:0], i[1] ? 2'h3 : 2'h1, i[0] ? 6'h04 : 6'h01},
                rd);
            chk("tags", {29'h0, i[2:0]}, {29'h0, tags});
            chk("cfg err", 0, cfg_err);
        end
        wb(8'h00, 1'b1, 32'hFFFFFFFF);
        wb(8'h00, 1'b0, 32'h0);
        chk("vc reg ro", {25'h0, 4'h1, 3'h7}, rd);
        wb(8'hFC, 1'b0, 32'h0);
        chk("unmapped err", 1, got_err);
        rsv_bad <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("cfg err rsv", 1, cfg_err);
        rsv_bad <= 1'b0;
        code <= 3'h1;
        repeat (2) @(posedge clk_i);
        burst;
        chk("grants", 2, grants);
        chk("tag full", 1, tag_full);
        wb(8'h10, 1'b0, 32'h0);
        chk("status full", 1, rd[7]);
        chk("status in use", 2, rd[6:1]);
        wb(8'h0C, 1'b1, 32'h00000001);
        wb(8'h0C, 1'b0, 32'h0);
        chk("tag cap", 1, rd);
        code <= 3'h3;
        tag_free_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        tag_free_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("tags freed", 0, tag_full);
        burst;
        chk("capped grants", 2, grants);
        chk("capped full", 1, tag_full);
        ce_i <= 1'b0;
        code <= 3'h5;
        repeat (3) @(posedge clk_i);
        chk("frozen lp vc", 3, lp_vc);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("lp vc resumed", 5, lp_vc);
        conclude;
    end
endmodule // test_pcie_capability_config_vector
